// [rtl/pap_consts.vh]
/*
 * Register offsets, field positions, reset values and pin modes for the
 * port A pin logic block.
 * Assumes an AHB-Lite slave with one aligned 32-bit word per register.
 */
// Function
// - unimplemented control bits always read zero
// - reset: direction ones, controls clear, latch low clears
// - oscillator-out pin drives quarter-rate clock in RC clock-out mode
// - master clear pin low holds device reset
// - bit-4 pin output is open drain only
// - bit-4 pin level feeds timer 0 clock
// - external clock mode 2 (no I/O) takes bit-7 pin as clock
// - direction one floats pin, zero drives latch (pin 3 drives comparator one in outputs mode; pin 5 is never driven)
// - data read returns pins; write replaces the whole latch
// - comparator input pins read back zero
// - oscillator-claimed pins 6,7 read zero, direction ignored
`ifndef PAP_CONSTS_VH
`define PAP_CONSTS_VH

// register indices as printed; byte address is four times the index
`define PAP_IDX_DATA 8'h05
`define PAP_IDX_CMP 8'h1F
`define PAP_IDX_DIR 8'h85
`define PAP_IDX_VREF 8'h9F
`define PAP_IDX_CFG 8'hC0

`define PAP_RST_DIR 8'hFF
`define PAP_RST_CMP 8'h00
`define PAP_RST_VREF 8'h00
`define PAP_RST_DATA_LOW 8'h00
`define PAP_RST_CFG 8'h00

// voltage reference control: bit 4 is unimplemented
`define PAP_VREF_MASK 8'hEF
// comparator control: bits 7:6 are comparator outputs, read only
`define PAP_CMP_WMASK 8'h3F
`define PAP_CMP_OUT2 7
`define PAP_CMP_OUT1 6
`define PAP_CMP_MODE_MSB 2
`define PAP_CMP_MODE_OFF 3'h7
`define PAP_CMP_MODE_OUTS 3'h6

// configuration register fields: oscillator mode and master clear enable
`define PAP_CFG_MASK 8'h0F
`define PAP_CFG_MASTER_CLEAR_N_BIT 3
`define PAP_OSC_XT 3'h0
`define PAP_OSC_EXT_IO 3'h1
`define PAP_OSC_EXT_CLK 3'h2
`define PAP_OSC_RC_IO 3'h3
`define PAP_OSC_RC_QUARTER_RATE_CLOCK_OUT 3'h4

`define PAP_HTRANS_NONSEQ 2'h2
`define PAP_QUARTER_DIV 2

`endif

// [rtl/pap_quarter_div.v]
/*
 * Divider producing a square clock at one quarter of the oscillator rate.
 * Assumes the oscillator is the block clock hclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pap_quarter_div #(
  parameter W = 2
) (
  input wire hclk,
  input wire hresetn,
  output wire clk_q
);
  reg [W-1:0] cnt_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= {W{1'b0}};
    end else begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
  // msb toggles every 2 cycles: period of 4 oscillator cycles
  assign clk_q = cnt_r[W-1];
endmodule
`default_nettype wire

// [rtl/pap_port_a.v]
/*
 * Port A pin logic: data latch, direction latch, comparator and voltage
 * reference control registers, alternate functions on pins 0..7.
 * Assumes an AHB-Lite master, pin inputs synchronous to hclk, and an
 * external comparator core supplying its two outputs.
 */
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pap_consts.vh"
module pap_port_a #(
  parameter WIDTH = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire por_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out,
  output reg [WIDTH-1:0] pin_oe,
  input wire comparator_one_out,
  input wire comparator_two_out,
  output reg timer0_ext_clock_in,
  output reg ext_clock_source_in,
  output reg device_reset_hold,
  output reg quarter_rate_clock_out
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [WIDTH-1:0] data_r;
  reg [WIDTH-1:0] dir_r;
  reg [7:0] cmp_r;
  reg [7:0] vref_r;
  reg [7:0] cfg_r;
  reg wr_pend_r;
  reg [7:0] wr_idx_r;
  reg qen_r;
  wire clk_q;
  wire [7:0] rst_data_low = `PAP_RST_DATA_LOW;

  function [7:0] word_idx;
    input [31:0] a;
    begin
      word_idx = a[9:2];
    end
  endfunction

  function is_mapped;
    input [7:0] i;
    begin
      is_mapped = (i == `PAP_IDX_DATA) || (i == `PAP_IDX_CMP) ||
                  (i == `PAP_IDX_DIR) || (i == `PAP_IDX_VREF) || (i == `PAP_IDX_CFG);
    end
  endfunction

  // ---------------------------------------------------------------
  // pin ownership
  // ---------------------------------------------------------------
  wire [2:0] osc_mode = cfg_r[2:0];
  wire [2:0] cmp_mode = cmp_r[`PAP_CMP_MODE_MSB:0];
  wire master_clear_n_en = cfg_r[`PAP_CFG_MASTER_CLEAR_N_BIT];
  // pin 7 is general I/O in the I/O and RC clock-out oscillator modes
  wire own7 = !((osc_mode == `PAP_OSC_EXT_IO) || (osc_mode == `PAP_OSC_RC_IO) ||
                (osc_mode == `PAP_OSC_RC_QUARTER_RATE_CLOCK_OUT));
  // pin 6 is claimed unless an I/O oscillator mode frees it
  wire own6 = !((osc_mode == `PAP_OSC_EXT_IO) || (osc_mode == `PAP_OSC_RC_IO));
  wire quarter_rate_clock_out_on = (osc_mode == `PAP_OSC_RC_QUARTER_RATE_CLOCK_OUT);
  // comparators on: pins 3:0 are analog inputs, only pins 1:0 in outputs mode
  wire [3:0] an_sel = (cmp_mode == `PAP_CMP_MODE_OFF) ? 4'h0 :
                      (cmp_mode == `PAP_CMP_MODE_OUTS) ? 4'h3 : 4'hF;
  wire cmp_outs = (cmp_mode == `PAP_CMP_MODE_OUTS);

  // per-pin digital read path; analog-selected inputs read zero
  wire [3:0] an_view;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_an_view
      assign an_view[g] = pin_in[g] & ~an_sel[g];
    end
  endgenerate

  reg [WIDTH-1:0] pin_view;
  always @* begin
    pin_view = pin_in;
    pin_view[3:0] = an_view;
    if (own6) begin
      pin_view[6] = 1'b0;
    end
    if (own7) begin
      pin_view[7] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // bus slave: zero-wait, always OKAY
  // ---------------------------------------------------------------
  wire take = hsel && hready && (htrans == `PAP_HTRANS_NONSEQ);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= take && hwrite;
      wr_idx_r <= word_idx(haddr);
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      if (take && !hwrite && is_mapped(word_idx(haddr))) begin
        case (word_idx(haddr))
          `PAP_IDX_DATA: hrdata <= {24'h000000, pin_view};
          `PAP_IDX_DIR: hrdata <= {24'h000000, dir_r};
          `PAP_IDX_CMP: hrdata <= {24'h000000, comparator_two_out,
                                   comparator_one_out, cmp_r[5:0]};
          `PAP_IDX_VREF: hrdata <= {24'h000000, vref_r & `PAP_VREF_MASK};
          `PAP_IDX_CFG: hrdata <= {24'h000000, cfg_r & `PAP_CFG_MASK};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_r <= `PAP_RST_DIR;
      cmp_r <= `PAP_RST_CMP;
      vref_r <= `PAP_RST_VREF;
      cfg_r <= `PAP_RST_CFG;
      data_r <= `PAP_RST_DATA_LOW;
    end else if (device_reset_hold || !por_n) begin
      // synchronous reset loads; bit 4 survives non-power-on resets
      dir_r <= `PAP_RST_DIR;
      cmp_r <= `PAP_RST_CMP;
      vref_r <= `PAP_RST_VREF;
      data_r[3:0] <= rst_data_low[3:0];
      if (!por_n) begin
        data_r <= `PAP_RST_DATA_LOW;
      end
    end else if (wr_pend_r) begin
      case (wr_idx_r)
        // written word replaces the whole data latch, no merge with pins
        `PAP_IDX_DATA: data_r <= hwdata[WIDTH-1:0];
        `PAP_IDX_DIR: dir_r <= hwdata[WIDTH-1:0];
        `PAP_IDX_CMP: cmp_r <= (cmp_r & ~`PAP_CMP_WMASK) | (hwdata[7:0] & `PAP_CMP_WMASK);
        `PAP_IDX_VREF: vref_r <= hwdata[7:0] & `PAP_VREF_MASK;
        `PAP_IDX_CFG: cfg_r <= hwdata[7:0] & `PAP_CFG_MASK;
        default: data_r <= data_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drivers and alternate function outputs
  // ---------------------------------------------------------------
  pap_quarter_div #(
    .W(`PAP_QUARTER_DIV)
  ) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_q(clk_q)
  );

  // ---------------------------------------------------------------
  // quarter clock gate
  // ---------------------------------------------------------------
  // gate opens and closes only while the divider is low: no cut pulses
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qen_r <= 1'b0;
    end else if (quarter_rate_clock_out_on) begin
      qen_r <= qen_r || !clk_q;
    end else begin
      qen_r <= qen_r && clk_q;
    end
  end
  wire q_gate = qen_r && clk_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= {WIDTH{1'b0}};
      pin_oe <= {WIDTH{1'b0}};
      timer0_ext_clock_in <= 1'b0;
      ext_clock_source_in <= 1'b0;
      device_reset_hold <= 1'b0;
      quarter_rate_clock_out <= 1'b0;
    end else begin
      pin_out <= data_r;
      pin_oe <= ~dir_r;
      if (cmp_outs) begin
        pin_out[3] <= comparator_one_out;
      end
      // bit-4 pin drives only low: data zero (comparator two output in outputs mode) enables drive
      pin_out[4] <= 1'b0;
      pin_oe[4] <= !dir_r[4] && !(cmp_outs ? comparator_two_out : data_r[4]);
      pin_out[5] <= 1'b0;
      pin_oe[5] <= 1'b0;
      if (own6) begin
        pin_out[6] <= q_gate;
        pin_oe[6] <= quarter_rate_clock_out_on;
      end
      if (own7) begin
        pin_oe[7] <= 1'b0;
      end
      timer0_ext_clock_in <= pin_in[4];
      ext_clock_source_in <= (osc_mode == `PAP_OSC_EXT_CLK) ? pin_in[7] : 1'b0;
      device_reset_hold <= master_clear_n_en && !pin_in[5];
      quarter_rate_clock_out <= q_gate;
    end
  end
endmodule
`default_nettype wire

// [dv/pap_board.sv]
/* board model of the port A pins.
   assumes ext gives the level of every undriven pin except pin 4, which is pulled up. */
`timescale 1ns/1ps
`default_nettype none
module pap_board (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext,
  output logic [7:0] pin_in
);
  // open-drain pin 4 has a pull-up
  always_comb begin
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ((i == 4) ? 1'h1 : ext[i]);
  end
endmodule
`default_nettype wire

// [dv/pap_port_a_sva.sv]
/* checker for the port A pins and alternate functions.
   assumes a bind into pap_port_a, one clock hclk. */
`timescale 1ns/1ps
`default_nettype none
module pap_port_a_sva #(
  parameter WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] hrdata,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic timer0_ext_clock_in,
  input wire logic ext_clock_source_in,
  input wire logic device_reset_hold,
  input wire logic quarter_rate_clock_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_od_pin4: assert property (pin_out[4] == 1'h0)
    else $error("pin 4 drives high");
  a_pin5_input: assert property (!pin_oe[5])
    else $error("pin 5 driven");
  a_t0_follow: assert property ($past(hresetn) |-> timer0_ext_clock_in == $past(pin_in[4]))
    else $error("timer clock wrong");
  a_hold_cause: assert property (device_reset_hold |-> !$past(pin_in[5]))
    else $error("hold without low pin");
  a_clk_cause: assert property (ext_clock_source_in |-> $past(pin_in[7]))
    else $error("clock source wrong");
  a_quarter_high: assert property ($rose(quarter_rate_clock_out) |=> quarter_rate_clock_out ##1 !quarter_rate_clock_out)
    else $error("quarter high wrong");
  a_quarter_low: assert property ($fell(quarter_rate_clock_out) |=> !quarter_rate_clock_out ##1 quarter_rate_clock_out)
    else $error("quarter low wrong");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  cover property ($rose(quarter_rate_clock_out));
  cover property (device_reset_hold);
  cover property (ext_clock_source_in);
endmodule
bind pap_port_a pap_port_a_sva #(.WIDTH(WIDTH)) i_sva (.hclk(hclk), .hresetn(hresetn),
  .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .timer0_ext_clock_in(timer0_ext_clock_in), .ext_clock_source_in(ext_clock_source_in),
  .device_reset_hold(device_reset_hold), .quarter_rate_clock_out(quarter_rate_clock_out));
`default_nettype wire

// [dv/testbench.sv]
/* testbench: AHB-Lite master and register model for port A.
   assumes pap_board on the pins and the checker bound in. */
`timescale 1ns/1ps
`default_nettype none
`include "pap_consts.vh"
module testbench;
  logic hclk = 0, hresetn = 0, por_n = 0, hsel = 0, hwrite = 0, c1 = 0, c2 = 0, p;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] ext = 8'hFF, pin_in, pin_out, pin_oe, m_dir, m_data, m_cmp;
  logic hreadyout, hresp, t0, cks, hold, qclk;
  wire hready = hreadyout;
  int miscompares = 0, checks_done = 0, cyc = 0, n;
  always #5 hclk = ~hclk;
  pap_port_a i_dut (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .comparator_one_out(c1), .comparator_two_out(c2),
    .timer0_ext_clock_in(t0), .ext_clock_source_in(cks), .device_reset_hold(hold),
    .quarter_rate_clock_out(qclk));
  pap_board i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    hsel <= 1'h1;
    htrans <= `PAP_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    bus(1'h0, idx, 8'h0);
    chk(hresp, 1'h0);
    chk(r, {24'h0, e});
  endtask
  // expected pin reads: analog inputs and claimed pins 6/7 read zero
  function automatic logic [7:0] lvl();
    logic [7:0] v;
    logic md6;
    md6 = m_cmp[2:0] == `PAP_CMP_MODE_OUTS;
    for (int i = 0; i < 8; i++)
      v[i] = (!m_dir[i] && i != 5) ? m_data[i] : ext[i];
    if (!m_dir[3] && md6) v[3] = c1;
    v[4] = m_dir[4] || (md6 ? c2 : m_data[4]);
    if (m_cmp[2:0] != `PAP_CMP_MODE_OFF) v[1:0] = 2'h0;
    if (m_cmp[2:0] < 3'h6) v[3:2] = 2'h0;
    v[7:6] = 2'h0;
    return v;
  endfunction
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    n = $urandom(86);
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    por_n <= 1'h1;
    {m_dir, m_data, m_cmp} = {8'hFF, 16'h0};
    rdc(`PAP_IDX_DIR, `PAP_RST_DIR);
    rdc(`PAP_IDX_CMP, `PAP_RST_CMP);
    rdc(`PAP_IDX_DATA, lvl());
    bus(1'h1, `PAP_IDX_VREF, 8'hFF);
    rdc(`PAP_IDX_VREF, 8'hEF);
    rdc(8'h10, 8'h0);
    $display("reset and map test done");
    for (int k = 0; k < 4; k++) begin
      m_cmp = (k == 0) ? `PAP_CMP_MODE_OFF : (k == 1) ? `PAP_CMP_MODE_OUTS : 8'($urandom % 6);
      m_dir = 8'($urandom);
      m_data = 8'($urandom);
      ext <= 8'($urandom);
      c1 <= 1'($urandom);
      c2 <= 1'($urandom);
      bus(1'h1, `PAP_IDX_CMP, m_cmp);
      bus(1'h1, `PAP_IDX_DIR, m_dir);
      bus(1'h1, `PAP_IDX_DATA, m_data);
      repeat (2) @(posedge hclk);
      chk(pin_oe[2:0], {~m_dir[2:0]});
      chk(pin_out[2:0], m_data[2:0]);
      rdc(`PAP_IDX_DATA, lvl());
      rdc(`PAP_IDX_CMP, {c2, c1, m_cmp[5:0]});
    end
    $display("port io test done");
    bus(1'h1, `PAP_IDX_DATA, 8'h1F);
    bus(1'h1, `PAP_IDX_CFG, 8'h08);
    ext <= 8'h00;
    repeat (3) @(posedge hclk);
    chk(hold, 1'h1);
    ext <= 8'h20;
    repeat (3) @(posedge hclk);
    rdc(`PAP_IDX_DIR, 8'hFF);
    bus(1'h1, `PAP_IDX_DIR, 8'h00);
    repeat (2) @(posedge hclk);
    chk(pin_oe[4], 1'h0);
    chk(pin_out[3:0], 4'h0);
    chk(t0, 1'h1);
    por_n <= 1'h0;
    @(posedge hclk);
    por_n <= 1'h1;
    bus(1'h1, `PAP_IDX_DIR, 8'h00);
    repeat (3) @(posedge hclk);
    chk(pin_oe[4], 1'h1);
    chk(t0, 1'h0);
    $display("reset source test done");
    bus(1'h1, `PAP_IDX_CFG, 8'h02);
    ext <= 8'h80;
    repeat (3) @(posedge hclk);
    chk(cks, 1'h1);
    chk(pin_oe[7], 1'h0);
    bus(1'h1, `PAP_IDX_CFG, 8'h04);
    repeat (4) @(posedge hclk);
    p = qclk;
    n = 0;
    repeat (40) begin
      @(posedge hclk);
      if (qclk === 1'h1 && p === 1'h0) n++;
      p = qclk;
    end
    chk(n, 10);
    chk(pin_oe[6], 1'h1);
    chk(pin_out[6], qclk);
    $display("clock mode test done");
    complete_run();
  end
endmodule
`default_nettype wire
